// >>> fts_pkg.sv
/*
  Constants and types shared by the flow-through burst memory block.
  Assumes one clock domain; the variant is fixed here at elaboration.
*/
`default_nettype none

package fts_pkg;

  // ==========================================================================
  // Variant and geometry
  // ==========================================================================
  localparam bit          WIDE_VARIANT = 1'b1;
  localparam int unsigned LANE_BITS    = 9;
  localparam int unsigned LANES        = WIDE_VARIANT ? 4 : 2;
  localparam int unsigned DATA_W       = LANES * LANE_BITS;
  localparam int unsigned ADDR_W       = WIDE_VARIANT ? 17 : 18;
  localparam int unsigned WORDS        = 1 << ADDR_W;
  localparam int unsigned BEAT_W       = 2;

  // ==========================================================================
  // Read capture buffer
  // ==========================================================================
  localparam int unsigned CAP_DEPTH    = 32;

  // ==========================================================================
  // Reset values
  // ==========================================================================
  localparam logic [ADDR_W-1:0] ADDR_RST = {ADDR_W{1'b0}};
  localparam logic [BEAT_W-1:0] BEAT_RST = 2'h0;

  // ==========================================================================
  // Access states
  // ==========================================================================
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_READ  = 3'b010,
    ST_WRITE = 3'b100
  } fts_state_type;

endpackage : fts_pkg

`default_nettype wire

// >>> fts_fifo.sv
/*
  Synchronous FIFO with valid/ready on both sides, width and depth as parameters.
  Assumes a single clock and an asynchronous active-low reset; depth a power of two.
*/
`default_nettype none

module fts_fifo #(
  parameter int unsigned WIDTH = 36,
  parameter int unsigned DEPTH = 32
) (
  input  wire logic             clk,
  input  wire logic             nrst,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);

  localparam int unsigned PW = $clog2(DEPTH);

  typedef struct packed {
    logic [PW-1:0] wr_ptr;
    logic [PW-1:0] rd_ptr;
    logic [PW:0]   count;
  } fts_fifo_state_type;

  fts_fifo_state_type s_q;
  fts_fifo_state_type s_d;
  logic [WIDTH-1:0]   mem_q [DEPTH];
  logic               push;
  logic               pop;

  // ==========================================================================
  // Flags
  // ==========================================================================
  assign in_ready  = (s_q.count != (PW+1)'(DEPTH));
  assign out_valid = (s_q.count != '0);
  assign out_data  = mem_q[s_q.rd_ptr];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    s_d = s_q;
    if (push) begin
      s_d.wr_ptr = s_q.wr_ptr + 1'b1;
    end
    if (pop) begin
      s_d.rd_ptr = s_q.rd_ptr + 1'b1;
    end
    case ({push, pop})
      2'b10:   s_d.count = s_q.count + 1'b1;
      2'b01:   s_d.count = s_q.count - 1'b1;
      default: s_d.count = s_q.count;
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[s_q.wr_ptr] <= in_data;
    end
  end

endmodule : fts_fifo

`default_nettype wire

// >>> fts_sram.sv
/*
  Synchronous burst memory with flow-through read data and a read capture stream.
  Assumes the far side is clocked logic sharing clk; burst order select only changes between accesses.
*/
// Operation
// - The array holds 128K words of 36 bits or 256K words of 18 bits per variant.
// - Address, write data and controls are captured on the clock edge; read data is unregistered.
// - One loaded address supplies four beats through the internal burst counter.
// - First-beat read data flows from the array in the same cycle the address was loaded.
// - With burst advance low the next three beats follow on the next three rising edges.
// - The burst counter orders follow-on addresses, interleaved or linear per order select.
// - Writes are timed internally and decided as late as the end of the write cycle.
// - Writes are controlled by global write, lane write gating and per-lane write selects.
// - The narrow variant has only the first two lane write selects.
// - Sleep request powers the device down asynchronously.
// - Address loads on controller strobe low, or processor strobe low with chip enable low.
// - Global write low writes all lanes and overrides the per-lane selects.
// - With lane write gating high the per-lane selects are ignored.
// - Output enable high releases data pins; low with chip selected drives them (here only in a read access with no write control and no sleep active).
`default_nettype none

module fts_sram (
  input  wire logic                          clk,
  input  wire logic                          nrst,
  input  wire logic [fts_pkg::ADDR_W-1:0]    addr,
  input  wire logic                          ctrl_addr_strobe_n,
  input  wire logic                          cpu_addr_strobe_n,
  input  wire logic                          chip_enable_n,
  input  wire logic                          select_high,
  input  wire logic                          select_low_n,
  input  wire logic                          burst_step_n,
  input  wire logic                          burst_order_sel,
  input  wire logic                          all_lanes_write_n,
  input  wire logic                          lane_write_gate_n,
  input  wire logic [fts_pkg::LANES-1:0]     lane_write_sel_n,
  input  wire logic                          sleep_request,
  input  wire logic                          out_enable_n,
  input  wire logic [fts_pkg::DATA_W-1:0]    dq_in,
  output logic      [fts_pkg::DATA_W-1:0]    dq_out,
  output logic                               dq_oe_n,
  output logic                               read_capture_ready,
  output logic                               read_valid,
  input  wire logic                          read_ready,
  output logic      [fts_pkg::DATA_W-1:0]    read_data
);
  import fts_pkg::*;

  typedef struct packed {
    fts_state_type     state;
    logic [ADDR_W-1:0] base;
    logic [BEAT_W-1:0] beat;
    logic              order;
    logic              fresh;
  } fts_core_type;

  fts_core_type      s_q;
  fts_core_type      s_d;
  logic [DATA_W-1:0] array_q [WORDS];
  logic [ADDR_W-1:0] cur_addr;
  logic              selected;
  logic              load;
  logic              lane_req;
  logic [LANES-1:0]  wr_mask;
  logic              cap_push;

  // ==========================================================================
  // Burst address arithmetic
  // ==========================================================================
  function automatic logic [BEAT_W-1:0] burst_low(input logic [BEAT_W-1:0] start,
                                                  input logic [BEAT_W-1:0] beat,
                                                  input logic              interleaved);
    burst_low = interleaved ? (start ^ beat) : BEAT_W'(start + beat);
  endfunction

  assign cur_addr = {s_q.base[ADDR_W-1:BEAT_W],
                     burst_low(s_q.base[BEAT_W-1:0], s_q.beat, s_q.order)};

  // ==========================================================================
  // Input decode
  // ==========================================================================
  assign selected = !chip_enable_n && select_high && !select_low_n;
  assign load     = !ctrl_addr_strobe_n || (!cpu_addr_strobe_n && !chip_enable_n);
  assign lane_req = !lane_write_gate_n && (lane_write_sel_n != '1);

  // Write lanes decided from the controls present at the closing edge
  always_comb begin
    wr_mask = '0;
    if (s_q.state == ST_WRITE || (s_q.state == ST_READ && !s_q.fresh)) begin
      if (!all_lanes_write_n) begin
        wr_mask = '1;
      end else if (!lane_write_gate_n) begin
        wr_mask = ~lane_write_sel_n;
      end
    end
    if (sleep_request || s_q.state == ST_IDLE) begin
      wr_mask = '0;
    end
  end

  // ==========================================================================
  // Burst counter and access state
  // ==========================================================================
  always_comb begin
    s_d       = s_q;
    s_d.fresh = 1'b0;
    if (sleep_request) begin
      s_d = s_q;
    end else if (load) begin
      s_d.base  = addr;
      s_d.beat  = BEAT_RST;
      s_d.order = burst_order_sel;
      s_d.fresh = !cpu_addr_strobe_n && !chip_enable_n;
      s_d.state = !selected ? ST_IDLE
                : ((!all_lanes_write_n || lane_req) && cpu_addr_strobe_n) ? ST_WRITE
                : ST_READ;
    end else if (s_q.state != ST_IDLE) begin
      if (!burst_step_n) begin
        s_d.beat = BEAT_W'(s_q.beat + 1'b1);
      end else begin
        s_d.beat = s_q.beat;
      end
      s_d.state = (!all_lanes_write_n || lane_req) ? ST_WRITE : ST_READ;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_q.state <= ST_IDLE;
      s_q.base  <= ADDR_RST;
      s_q.beat  <= BEAT_RST;
      s_q.order <= 1'b0;
      s_q.fresh <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================================================
  // Array, self-timed lane writes
  // ==========================================================================
  always_ff @(posedge clk) begin
    for (int l = 0; l < LANES; l++) begin
      if (wr_mask[l]) begin
        array_q[cur_addr][l*LANE_BITS +: LANE_BITS] <= dq_in[l*LANE_BITS +: LANE_BITS];
      end
    end
  end

  // ==========================================================================
  // Flow-through read path and drivers
  // ==========================================================================
  assign dq_out  = array_q[cur_addr];
  assign dq_oe_n = out_enable_n || sleep_request || (s_q.state != ST_READ)
                   || !all_lanes_write_n || lane_req;

  // ==========================================================================
  // Read capture stream
  // ==========================================================================
  assign cap_push = (s_q.state == ST_READ) && !sleep_request
                    && all_lanes_write_n && !lane_req;

  fts_fifo #(
    .WIDTH (DATA_W),
    .DEPTH (CAP_DEPTH)
  ) u_capture (
    .clk       (clk),
    .nrst      (nrst),
    .in_valid  (cap_push),
    .in_ready  (read_capture_ready),
    .in_data   (dq_out),
    .out_valid (read_valid),
    .out_ready (read_ready),
    .out_data  (read_data)
  );

endmodule : fts_sram

`default_nettype wire

// >>> fts_sram_assertions.sv
/*
  Port-level checker for the flow-through burst memory.
  Assumes it is bound to fts_sram and shares its single clock and reset.
*/
`default_nettype none

module fts_sram_assertions (
  input wire logic                       clk,
  input wire logic                       nrst,
  input wire logic                       ctrl_addr_strobe_n,
  input wire logic                       cpu_addr_strobe_n,
  input wire logic                       chip_enable_n,
  input wire logic                       select_high,
  input wire logic                       select_low_n,
  input wire logic                       burst_step_n,
  input wire logic                       all_lanes_write_n,
  input wire logic                       lane_write_gate_n,
  input wire logic [fts_pkg::LANES-1:0]  lane_write_sel_n,
  input wire logic                       sleep_request,
  input wire logic                       out_enable_n,
  input wire logic [fts_pkg::DATA_W-1:0] dq_out,
  input wire logic                       dq_oe_n,
  input wire logic                       read_capture_ready,
  input wire logic                       read_valid,
  input wire logic                       read_ready,
  input wire logic [fts_pkg::DATA_W-1:0] read_data
);
  timeunit 1ns;
  timeprecision 1ps;
  import fts_pkg::*;
  logic load, sel, no_wr, rd_q;
  assign load  = !ctrl_addr_strobe_n || (!cpu_addr_strobe_n && !chip_enable_n);
  assign sel   = !chip_enable_n && select_high && !select_low_n;
  assign no_wr = all_lanes_write_n && (lane_write_gate_n || (&lane_write_sel_n));
  // Tracks a selected read access in progress
  always_ff @(posedge clk or negedge nrst)
    if (!nrst) rd_q <= 1'b0;
    else if (load && !sleep_request) rd_q <= sel && (no_wr || ctrl_addr_strobe_n);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  chk_oe_release: assert property (out_enable_n |-> dq_oe_n)
    else $error("data driven with output enable off");
  chk_sleep_off: assert property (sleep_request |-> dq_oe_n)
    else $error("data driven during sleep");
  chk_sleep_hold: assert property (sleep_request [*2] |-> $stable(dq_out))
    else $error("read data moved during sleep");
  chk_read_drive: assert property (load && sel && no_wr && !sleep_request ##1
    (!out_enable_n && no_wr && !sleep_request && !load) |-> !dq_oe_n)
    else $error("selected read not driving data");
  chk_deselect_off: assert property (load && !sel && !sleep_request |=> dq_oe_n)
    else $error("deselected device drives data");
  chk_write_off: assert property (!all_lanes_write_n |-> dq_oe_n)
    else $error("data driven during write");
  chk_hold_repeat: assert property (rd_q && !load && burst_step_n && no_wr
    && !sleep_request |=> $stable(dq_out))
    else $error("read data moved without advance or load");
  chk_fifo_hold: assert property (read_valid && !read_ready |=> read_valid && $stable(read_data))
    else $error("capture head changed while stalled");
  chk_fifo_full: assert property (!read_capture_ready |-> read_valid)
    else $error("capture buffer full yet empty");
  cov_burst: cover property (rd_q && !burst_step_n);
  cov_full: cover property (!read_capture_ready);
  cov_sleep: cover property (rd_q && sleep_request);
endmodule // fts_sram_assertions

`default_nettype wire

// >>> fts_bus_model.sv
/*
  Cache-controller model driving the memory's synchronous inputs.
  Assumes the testbench calls its tasks and shares clk with the memory.
*/
`default_nettype none

module fts_bus_model (
  input  wire logic                       clk,
  output logic [fts_pkg::ADDR_W-1:0]      addr,
  output logic                            ctrl_addr_strobe_n,
  output logic                            cpu_addr_strobe_n,
  output logic                            chip_enable_n,
  output logic                            select_high,
  output logic                            select_low_n,
  output logic                            burst_step_n,
  output logic                            burst_order_sel,
  output logic                            all_lanes_write_n,
  output logic                            lane_write_gate_n,
  output logic [fts_pkg::LANES-1:0]       lane_write_sel_n,
  output logic [fts_pkg::DATA_W-1:0]      dq_in
);
  timeunit 1ns;
  timeprecision 1ps;
  import fts_pkg::*;
  task automatic put(input logic lc, lp, ce, input logic [ADDR_W-1:0] a, input logic st,
                     gw, gt, input logic [LANES-1:0] bs, input logic [DATA_W-1:0] d);
    ctrl_addr_strobe_n = !lc;
    cpu_addr_strobe_n  = !lp;
    chip_enable_n      = ce;
    addr               = a;
    burst_step_n       = st;
    all_lanes_write_n  = gw;
    lane_write_gate_n  = gt;
    lane_write_sel_n   = bs;
    dq_in              = (gw && gt) ? ~dq_in : d;
  endtask
  task automatic drive(input logic lc, lp, ce, input logic [ADDR_W-1:0] a, input logic st,
                       gw, gt, input logic [LANES-1:0] bs, input logic [DATA_W-1:0] d);
    @(posedge clk);
    #1;
    put(lc, lp, ce, a, st, gw, gt, bs, d);
  endtask
  // Only called between accesses, never mid-burst
  task automatic set_order(input logic o);
    burst_order_sel = o;
  endtask
  initial begin
    select_high     = 1'b1;
    select_low_n    = 1'b0;
    burst_order_sel = 1'b0;
    dq_in           = '0;
    put(1'b0, 1'b0, 1'b1, '0, 1'b1, 1'b1, 1'b1, '1, '0);
  end
endmodule // fts_bus_model

`default_nettype wire

// >>> fts_sram_tb_top.sv
/*
  Self-checking testbench for the flow-through burst memory.
  Assumes package, FIFO, memory, bus model and checker are compiled before it.
*/
`default_nettype none

module fts_sram_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import fts_pkg::*;
  logic clk, nrst, sleep_request, out_enable_n, read_ready, ctrl_addr_strobe_n, cpu_addr_strobe_n;
  logic chip_enable_n, select_high, select_low_n, burst_step_n, burst_order_sel, dq_oe_n;
  logic all_lanes_write_n, lane_write_gate_n, read_capture_ready, read_valid;
  logic [ADDR_W-1:0] addr;
  logic [LANES-1:0]  lane_write_sel_n;
  logic [DATA_W-1:0] dq_in, dq_out, read_data;
  logic [DATA_W-1:0] exp_mem [int];
  int                miscompares = 0;
  int                num_checks = 0;
  int                cycles = 0;
  fts_sram fts_sram_inst (.*);
  fts_bus_model fts_bus_model_inst (.*);
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      miscompares++;
      end_sim();
    end
  end
  task automatic end_sim();
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic check(input string what, input logic [DATA_W-1:0] exp, got);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic go(input logic lc, lp, ce, input int a, input logic st);
    fts_bus_model_inst.drive(lc, lp, ce, ADDR_W'(a), st, 1'b1, 1'b1, '1, '0);
  endtask
  task automatic wr(input int a, input logic gw, gt, late, input logic [LANES-1:0] bs,
                    input logic [DATA_W-1:0] d);
    fts_bus_model_inst.drive(1'b1, 1'b0, 1'b0, ADDR_W'(a), 1'b1, gw | late, gt | late, bs, d);
    fts_bus_model_inst.drive(1'b0, 1'b0, 1'b0, ADDR_W'(a), 1'b1, gw, gt, bs, d);
    // Deselect so the next load edge does not also close a write cycle
    go(1'b1, 1'b0, 1'b1, a, 1'b1);
    for (int l = 0; l < LANES; l++)
      if (!gw || (!gt && !bs[l])) exp_mem[a][l*LANE_BITS +: LANE_BITS] = d[l*LANE_BITS +: LANE_BITS];
  endtask
  task automatic burst(input int a, input logic ord, input int hold);
    logic [1:0] b;
    logic       st;
    b = 2'h0;
    fts_bus_model_inst.set_order(ord);
    go(1'b1, 1'b0, 1'b0, a, 1'b1);
    for (int i = 0; i < (hold < 4 ? 5 : 4); i++) begin
      st = (i == hold) || (b == 2'h3);
      go(1'b0, 1'b0, 1'b0, a, st);
      check("burst word", exp_mem[{a[31:2], ord ? a[1:0] ^ b : a[1:0] + b}], dq_out);
      check("burst oe_n", '0, dq_oe_n);
      if (!st) b++;
    end
    go(1'b1, 1'b0, 1'b1, a, 1'b1);
  endtask
  task automatic s_bursts();
    for (int i = 0; i < 4; i++) wr(8 + i, 1'b0, 1'b1, 1'b0, '1, 36'h5_A5A5_0000 + DATA_W'(i));
    burst(10, 1'b0, 9);
    burst(9, 1'b1, 1);
  endtask
  task automatic s_lanes();
    wr(8, 1'b1, 1'b0, 1'b0, 4'hA, 36'hF_0F0F_0F0F);
    wr(9, 1'b1, 1'b1, 1'b0, 4'h0, 36'hC_3333_3333);
    wr(10, 1'b0, 1'b0, 1'b0, 4'hF, 36'hE_1234_5678);
    wr(11, 1'b0, 1'b1, 1'b1, 4'hF, 36'h7_7777_7777);
    burst(8, 1'b0, 9);
  endtask
  task automatic s_strobe_sleep();
    go(1'b0, 1'b1, 1'b0, 10, 1'b1);
    go(1'b0, 1'b1, 1'b1, 8, 1'b1);
    check("cpu load", exp_mem[10], dq_out);
    go(1'b0, 1'b0, 1'b0, 8, 1'b0);
    check("gated load", exp_mem[10], dq_out);
    sleep_request = 1'b1;
    repeat (2) go(1'b0, 1'b0, 1'b0, 8, 1'b0);
    check("sleep oe_n", DATA_W'(1'b1), dq_oe_n);
    check("sleep hold", exp_mem[10], dq_out);
    sleep_request = 1'b0;
    out_enable_n = 1'b1;
    go(1'b0, 1'b0, 1'b0, 8, 1'b1);
    check("step after sleep", exp_mem[11], dq_out);
    check("oe off", DATA_W'(1'b1), dq_oe_n);
    out_enable_n = 1'b0;
    go(1'b1, 1'b0, 1'b1, 8, 1'b1);
  endtask
  task automatic s_fifo();
    int n;
    n = 0;
    repeat (3) go(1'b0, 1'b0, 1'b1, 9, 1'b1);
    check("fifo empty", '0, read_valid);
    read_ready = 1'b0;
    go(1'b1, 1'b0, 1'b0, 9, 1'b1);
    repeat (40) go(1'b0, 1'b0, 1'b0, 9, 1'b1);
    check("fifo full", '0, read_capture_ready);
    go(1'b1, 1'b0, 1'b1, 9, 1'b1);
    go(1'b0, 1'b0, 1'b1, 9, 1'b1);
    check("fifo head", exp_mem[9], read_data);
    read_ready = 1'b1;
    repeat (40) begin
      if (read_valid === 1'b1) n++;
      @(posedge clk);
      #1;
    end
    check("fifo count", DATA_W'(CAP_DEPTH), DATA_W'(n));
  endtask
  initial begin
    nrst          = 1'b0;
    sleep_request = 1'b0;
    out_enable_n  = 1'b0;
    read_ready    = 1'b1;
    repeat (12) @(posedge clk);
    #1;
    nrst = 1'b1;
    s_bursts();
    s_lanes();
    s_strobe_sleep();
    s_fifo();
    end_sim();
  end
endmodule // fts_sram_tb_top

bind fts_sram fts_sram_assertions fts_sram_assertions_inst (.*);

`default_nettype wire
